// *** ocfr_pkg.sv ***
// package: constants, field layout, states and the state record for the
// overcurrent fault response block.
// assumes a 100 MHz core clock and a command decoder on the same clock.
`default_nettype none

package ocfr_pkg;

    // command code of the response setting
    localparam logic [7:0] OCFR_CMD_CODE      = 8'h00_E5;
    // field positions inside the setting byte
    localparam int         OCFR_RESP_HI       = 7;
    localparam int         OCFR_RESP_LO       = 6;
    localparam int         OCFR_RETRY_HI      = 5;
    localparam int         OCFR_RETRY_LO      = 3;
    localparam int         OCFR_DELAY_HI      = 2;
    localparam int         OCFR_DELAY_LO      = 0;
    // field encodings
    localparam logic [1:0] OCFR_RESP_DISABLE  = 2'h2;
    localparam logic [2:0] OCFR_RETRY_NONE    = 3'h0;
    // reset value before the strap is taken
    localparam logic [7:0] OCFR_SETTING_RESET = 8'h00_00;

    // timing: one retry unit is 35 ms
    localparam int unsigned OCFR_CLK_KHZ      = 100000;
    localparam int unsigned OCFR_RETRY_UNIT_MS = 35;
    localparam int unsigned OCFR_TICK_CYCLES  =
        OCFR_RETRY_UNIT_MS * OCFR_CLK_KHZ;
    localparam int          OCFR_TICK_W       = 22;
    // cycles after reset release before the synchronised strap is taken
    localparam logic [1:0]  OCFR_STRAP_WAIT   = 2'h2;

    // response sequencer states
    typedef enum logic [1:0] {
        OCFR_ST_RUN   = 2'b00,
        OCFR_ST_HOLD  = 2'b01,
        OCFR_ST_RETRY = 2'b10
    } ocfr_state_type;

    // two-stage synchronisers for the pins
    typedef struct packed {
        logic [7:0] strap;
        logic       oc_fault;
        logic       control_on;
        logic       bias_ok;
    } ocfr_pins_type;

    // complete state of the block
    typedef struct packed {
        ocfr_pins_type              sync1;
        ocfr_pins_type              sync2;
        logic [1:0]                 strap_cnt;
        logic                       strap_done;
        logic [7:0]                 setting;
        ocfr_state_type             state;
        logic [OCFR_TICK_W-1:0]     prescale;
        logic [3:0]                 ticks;
        logic                       oc_status;
        logic                       restart;
        logic [7:0]                 rdata;
    } ocfr_regs_type;

endpackage : ocfr_pkg

`default_nettype wire

// *** ocfr_core.sv ***
// overcurrent fault response: setting byte, sticky status, alert line,
// output disable and timed automatic restart.
// assumes a command decoder on clk_i that presents one command per strobe,
// and raw pins (fault comparator, control pin, bias good, strap) that are
// asynchronous to clk_i.
// every pin is resampled by two flip-flops, so each pin response lags
// its pin by two clock edges; the output disable itself is combinational
// from the synchronised fault, so the power stage drops in the very
// cycle in which the fault is detected.
//
// Notes on behaviour
// [R1] response 10 disables output at once, then retries
// [R2] any overcurrent fault pulls the alert line low; the code flags only a fault seen in run while the output is commanded on
// [R3] overcurrent fault sets the output-current status bit
// [R4] fault bit cleared only by clear faults
// [R5] retry 000 keeps output off until cleared
// [R6] retries 001-111 restart without rechecking the fault
// [R7] off command, bias loss, other fault stop retries
// [R8] retry interval is (delay plus one) times 35 ms
// [R9] delay counted from fault detection to restart
// [R10] setting is one read/write protectable byte, code E5h
// [R11] setting starts from the configuration pin strap
// [R12] host should keep the default no-retry setting
// [R13] no automatic retry inside fault or sequencing groups
// [R14] 35 ms prescaler tick, delay plus one ticks
`timescale 1ns/1ps
`default_nettype none

module ocfr_core
    import ocfr_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = OCFR_TICK_CYCLES
)(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    // command port from the bus decoder
    input  wire logic       cmd_valid_i,
    input  wire logic       cmd_write_i,
    input  wire logic [7:0] cmd_code_i,
    input  wire logic [7:0] cmd_wdata_i,
    input  wire logic       write_protect_i,
    input  wire logic       clear_faults_i,
    output logic            cmd_ack_o,
    output logic [7:0]      cmd_rdata_o,
    // raw pins
    input  wire logic       oc_fault_i,
    input  wire logic       control_on_i,
    input  wire logic       bias_ok_i,
    input  wire logic [7:0] strap_cfg_i,
    // same-clock controls
    input  wire logic       operation_on_i,
    input  wire logic       other_fault_off_i,
    input  wire logic       group_member_i,
    // outputs to power stage and host
    output logic            output_enable_o,
    output logic            host_alert_output_o,
    output logic            host_alert_output_oe_n_o,
    output logic            status_oc_o,
    output logic            restart_o,
    output logic [7:0]      setting_o
);

    // state record and its next value: every flip-flop of the block lives
    // in state_reg, and state_next is built for the next edge by one
    // combinational process below
    ocfr_regs_type state_reg;
    ocfr_regs_type state_next;

    // command decode
    logic       hit;

    // run conditions seen by the sequencer
    logic       commanded_on;
    logic       stop_retry;
    logic       fault_seen;

    // fields of the setting byte
    logic [1:0] resp_field;
    logic [2:0] retry_field;
    logic [2:0] delay_field;

    // one pulse per retry unit
    logic       tick;

    // command hit on the one mapped code; other codes belong to other
    // blocks and are neither acked nor stored here
    assign hit = cmd_valid_i
                 && (cmd_code_i == OCFR_CMD_CODE); // [R10]

    // acknowledge is combinational so the decoder sees it in its cycle
    assign cmd_ack_o = hit;

    // setting fields
    assign resp_field  = state_reg.setting[OCFR_RESP_HI:OCFR_RESP_LO];
    assign retry_field = state_reg.setting[OCFR_RETRY_HI:OCFR_RETRY_LO];
    assign delay_field = state_reg.setting[OCFR_DELAY_HI:OCFR_DELAY_LO];

    // on only while both the pin and the operation command ask for it
    assign commanded_on = state_reg.sync2.control_on && operation_on_i;
    // any one of these ends a retry sequence: off by pin or by command,
    // bias lost, or another fault that shuts the unit down
    assign stop_retry   = !commanded_on
                          || !state_reg.sync2.bias_ok
                          || other_fault_off_i; // [R7]

    // fault only counts in run while the output is commanded on; a fault that lasts
    // through a restart is caught again in the restart cycle itself
    assign fault_seen = state_reg.sync2.oc_fault
                        && (state_reg.state == OCFR_ST_RUN)
                        && commanded_on;

    // 35 ms prescaler tick; the compare is cut to the counter width on
    // purpose, so TICK_CYCLES must fit in OCFR_TICK_W bits
    assign tick = (state_reg.prescale
                   == OCFR_TICK_W'(TICK_CYCLES - 1)); // [R14]

    // next-state logic
    always_comb
    begin
        state_next         = state_reg;
        state_next.restart = 1'b0;

        // two-flop synchronisers on every pin; only sync2 reads sync1, so
        // a metastable first stage never reaches the sequencer
        state_next.sync1.strap      = strap_cfg_i;
        state_next.sync1.oc_fault   = oc_fault_i;
        state_next.sync1.control_on = control_on_i;
        state_next.sync1.bias_ok    = bias_ok_i;
        state_next.sync2            = state_reg.sync1;

        // take the strap once it has passed the synchroniser; a write that
        // arrives before that is dropped
        if (!state_reg.strap_done)
        begin
            if (state_reg.strap_cnt == OCFR_STRAP_WAIT)
            begin
                state_next.setting    = state_reg.sync2.strap; // [R11]
                state_next.strap_done = 1'b1;
            end
            else
            begin
                state_next.strap_cnt = state_reg.strap_cnt + 2'h1;
            end
        end
        // protected writes are still acked but leave the byte alone
        else if (hit && cmd_write_i && !write_protect_i)
        begin
            state_next.setting = cmd_wdata_i; // [R10]
        end

        // read data for the mapped code, zero otherwise
        // read data stands for the one cycle after the hit
        if (hit)
        begin
            state_next.rdata = state_reg.setting;
        end
        else
        begin
            state_next.rdata = 8'h00_00;
        end

        // sticky status: a new fault wins over the clear, so no fault is
        // lost between the host reading the status and clearing it
        if (clear_faults_i)
        begin
            state_next.oc_status = 1'b0; // [R4]
        end
        if (fault_seen)
        begin
            state_next.oc_status = 1'b1; // [R3]
        end

        // prescaler free-runs, restarted at fault detection so that the
        // first retry unit is a whole one
        if (tick)
        begin
            state_next.prescale = '0;
        end
        else
        begin
            state_next.prescale = state_reg.prescale + OCFR_TICK_W'(1);
        end

        // response sequencer: hold and retry keep the output off, and
        // only run lets it on
        case (state_reg.state)
            OCFR_ST_RUN:
            begin
                // responses other than 10 only flag the fault; the output
                // then follows the fault level through output_enable_o
                if (fault_seen && (resp_field == OCFR_RESP_DISABLE))
                begin
                    state_next.prescale = '0; // [R9]
                    state_next.ticks    = '0;
                    if ((retry_field == OCFR_RETRY_NONE)
                        || group_member_i) // [R5] [R13]
                    begin
                        state_next.state = OCFR_ST_HOLD;
                    end
                    else
                    begin
                        state_next.state = OCFR_ST_RETRY; // [R1]
                    end
                end
            end

            OCFR_ST_HOLD:
            begin
                // output stays off until the host clears faults; a fault
                // still present then is caught again from run
                if (clear_faults_i && !fault_seen)
                begin
                    state_next.state = OCFR_ST_RUN; // [R5]
                end
            end

            OCFR_ST_RETRY:
            begin
                // the timer counts delay plus one ticks from the prescaler
                // restart, so the attempt lands (delay+1)*TICK_CYCLES
                // cycles after detection
                if (stop_retry)
                begin
                    state_next.state = OCFR_ST_RUN; // [R7]
                end
                else if (tick)
                begin
                    if (state_reg.ticks == {1'b0, delay_field})
                    begin
                        // restart without looking at the fault input
                        state_next.state   = OCFR_ST_RUN; // [R6]
                        state_next.restart = 1'b1;
                    end
                    else
                    begin
                        state_next.ticks = state_reg.ticks + 4'h1; // [R8]
                    end
                end
            end

            default:
            begin
                // an illegal code parks the output off until cleared
                state_next.state = OCFR_ST_HOLD;
            end
        endcase
    end

    // state register; reset loads constants only, and the strap is taken
    // later through the synchroniser so a late-settling pin is still seen
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            state_reg            <= '0;
            state_reg.setting    <= OCFR_SETTING_RESET;
            state_reg.state      <= OCFR_ST_RUN;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // output drive: disabled at once when the fault is seen; bias loss
    // and another shutdown fault gate it off whatever the state
    assign output_enable_o = commanded_on
                             && (state_reg.state == OCFR_ST_RUN)
                             && !fault_seen
                             && !other_fault_off_i
                             && state_reg.sync2.bias_ok; // [R1]

    // open-drain alert: pulled low while the status bit stands, so the
    // host sees the alert until it clears faults
    assign host_alert_output_o      = 1'b0;
    assign host_alert_output_oe_n_o = !state_reg.oc_status; // [R2]

    // registered status outputs; restart_o is a one-cycle pulse
    assign status_oc_o = state_reg.oc_status;
    assign restart_o   = state_reg.restart;
    assign setting_o   = state_reg.setting;
    assign cmd_rdata_o = state_reg.rdata;

endmodule : ocfr_core

`default_nettype wire

// *** ocfr_properties.sv ***
// checker: port properties of ocfr_core, bound to every instance
// assumes the bench holds reset_i high before any traffic
`timescale 1ns/1ps
`default_nettype none
module ocfr_properties
    import ocfr_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = OCFR_TICK_CYCLES
)(
    // clock, reset and command side
    input wire logic       clk_i,
    input wire logic       reset_i,
    input wire logic       cmd_valid_i,
    input wire logic       cmd_write_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic [7:0] cmd_wdata_i,
    input wire logic       write_protect_i,
    input wire logic       clear_faults_i,
    input wire logic       cmd_ack_o,
    input wire logic [7:0] cmd_rdata_o,
    // controls and outputs
    input wire logic       operation_on_i,
    input wire logic       other_fault_off_i,
    input wire logic       group_member_i,
    input wire logic       output_enable_o,
    input wire logic       host_alert_output_o,
    input wire logic       host_alert_output_oe_n_o,
    input wire logic       status_oc_o,
    input wire logic       restart_o,
    input wire logic [7:0] setting_o
);
    logic [31:0] gap_reg;
    logic [31:0] need;
    logic        hit;
    // cycles since output_enable_o last fell or the last restart
    always_ff @(posedge clk_i or posedge reset_i)
        if (reset_i) gap_reg <= '0;
        else if ($fell(output_enable_o) || restart_o) gap_reg <= '0;
        else gap_reg <= gap_reg + 32'h0000_0001;
    assign need = (32'(setting_o[2:0]) + 32'h0000_0001) * TICK_CYCLES;
    assign hit  = cmd_valid_i && cmd_code_i == OCFR_CMD_CODE;
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    property p_ack; cmd_ack_o == hit; endproperty
    a_ack: assert property (p_ack) else $error("ack wrong");
    property p_rd; hit && !cmd_write_i |=> cmd_rdata_o == $past(setting_o);
    endproperty
    a_rd: assert property (p_rd) else $error("read data wrong");
    property p_wr; hit && cmd_write_i && !write_protect_i
        |=> setting_o == $past(cmd_wdata_i); endproperty
    a_wr: assert property (p_wr) else $error("write lost");
    property p_wp; hit && cmd_write_i && write_protect_i |=> $stable(setting_o);
    endproperty
    a_wp: assert property (p_wp) else $error("protect broken");
    property p_alert; !host_alert_output_o
        && host_alert_output_oe_n_o == !status_oc_o; endproperty
    a_alert: assert property (p_alert) else $error("alert wrong");
    property p_sticky; $fell(status_oc_o) |-> $past(clear_faults_i); endproperty
    a_sticky: assert property (p_sticky) else $error("status lost");
    property p_hold; $rose(status_oc_o) && setting_o[7:3] == 5'h10
        |-> !output_enable_o [*8]; endproperty
    a_hold: assert property (p_hold) else $error("output back on");
    property p_noretry; setting_o[5:3] == 3'h0 || group_member_i |-> !restart_o;
    endproperty
    a_noretry: assert property (p_noretry) else $error("retry");
    property p_gap; restart_o |-> gap_reg + 1 >= need && gap_reg <= need + 1;
    endproperty
    a_gap: assert property (p_gap) else $error("interval");
    property p_stop; restart_o |-> $past(operation_on_i && !other_fault_off_i);
    endproperty
    a_stop: assert property (p_stop) else $error("retry after stop");
    // main scenarios reached
    c_restart: cover property (restart_o);
    c_hold: cover property ($rose(status_oc_o) && setting_o[5:3] == 3'h0);
    c_wp: cover property (hit && cmd_write_i && write_protect_i);
endmodule : ocfr_properties
bind ocfr_core ocfr_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (.*);
`default_nettype wire

// *** ocfr_host.sv ***
// partner: host side of the command port with one byte transfer task
// assumes one shared clock; requests change on the falling edge
`timescale 1ns/1ps
`default_nettype none
module ocfr_host (
    // clock and answers
    input  wire logic       clk_i,
    input  wire logic       cmd_ack_i,
    input  wire logic [7:0] cmd_rdata_i,
    // request
    output logic            cmd_valid_o,
    output logic            cmd_write_o,
    output logic [7:0]      cmd_code_o,
    output logic [7:0]      cmd_wdata_o
);
    // request held across the taking edge, read byte taken a cycle later
    task automatic xfer(input logic w, input logic [7:0] c,
                        input logic [7:0] d, output logic [7:0] rd,
                        output logic ack);
        @(negedge clk_i);
        cmd_valid_o = 1'b1;
        cmd_write_o = w;
        cmd_code_o  = c;
        cmd_wdata_o = d;
        @(posedge clk_i);
        ack = cmd_ack_i;
        @(negedge clk_i);
        rd = cmd_rdata_i;
        cmd_valid_o = 1'b0;
        cmd_wdata_o = ~d;  // released data must not linger
    endtask : xfer
    // idle bus at time zero
    initial
    begin
        cmd_valid_o = 1'b0;
        cmd_write_o = 1'b0;
        cmd_code_o  = 8'h0000;
        cmd_wdata_o = 8'h0000;
    end
endmodule : ocfr_host
`default_nettype wire

// *** ocfr_core_bench.sv ***
// bench: command transfers and fault scenarios for ocfr_core
// assumes the 35 ms prescaler shortened to 10 cycles
`timescale 1ns/1ps
`default_nettype none
module ocfr_core_bench;
    import ocfr_pkg::*;
    logic       clk_i, reset_i, wp, clr, oc, con, bias, op, oth, grp;
    logic       valid, wr, ack, oe, alert, alert_oe_n, stat, rst_p, ack_v;
    logic [7:0] code, wdata, rdata, strap, setting, rd_v;
    logic [3:0] stop_v [4] = '{4'h6, 4'hA, 4'hC, 4'hF};
    int         num_errors, compares, n;
    ocfr_core #(.TICK_CYCLES(10)) dut (.clk_i(clk_i), .reset_i(reset_i),
        .cmd_valid_i(valid), .cmd_write_i(wr), .cmd_code_i(code),
        .cmd_wdata_i(wdata), .write_protect_i(wp), .clear_faults_i(clr),
        .cmd_ack_o(ack), .cmd_rdata_o(rdata), .oc_fault_i(oc),
        .control_on_i(con), .bias_ok_i(bias), .strap_cfg_i(strap),
        .operation_on_i(op), .other_fault_off_i(oth), .group_member_i(grp),
        .output_enable_o(oe), .host_alert_output_o(alert),
        .host_alert_output_oe_n_o(alert_oe_n), .status_oc_o(stat),
        .restart_o(rst_p), .setting_o(setting));
    ocfr_host host (.clk_i(clk_i), .cmd_ack_i(ack), .cmd_rdata_i(rdata),
        .cmd_valid_o(valid), .cmd_write_o(wr), .cmd_code_o(code),
        .cmd_wdata_o(wdata));
    // 100 MHz clock
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        if (got !== exp)
            num_errors++;
    endtask : check
    task automatic cyc(input int k);
        repeat (k) @(negedge clk_i);
    endtask : cyc
    // cycles until a restart pulse, -1 if none within the limit
    task automatic wait_rst(input int lim);
        n = -1;
        for (int i = 0; i < lim && n < 0; i++)
        begin
            @(negedge clk_i);
            if (rst_p === 1'b1) n = i;
        end
    endtask : wait_rst
    task automatic wrap_up;
        $display("compares=%0d mismatches=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : wrap_up
    // watchdog: the tests need well under 2000 cycles
    initial
    begin
        #100_000;
        num_errors++;
        wrap_up();
    end
    // strap default is latch off with no retry
    initial
    begin
        {reset_i, wp, clr, oc, grp, con, bias, op, oth} = 9'h10E;
        {strap, num_errors, compares} = {8'h0080, 32'h0, 32'h0};
        cyc(8);
        reset_i = 1'b0;
        cyc(6);
        host.xfer(1'b0, OCFR_CMD_CODE, 8'h0000, rd_v, ack_v);
        check(rd_v, strap);
        host.xfer(1'b0, 8'h00E6, 8'h0000, rd_v, ack_v);
        check({ack_v, rd_v[6:0]}, 8'h0000);
        wp = 1'b1;
        host.xfer(1'b1, OCFR_CMD_CODE, 8'h0055, rd_v, ack_v);
        wp = 1'b0;
        check(setting, strap);
        $display("test 1 done");
        oc = 1'b1;
        cyc(4);
        check({alert, oe, stat, alert_oe_n}, 8'h0002);
        oc = 1'b0;
        cyc(40);
        check({alert, oe, stat, alert_oe_n}, 8'h0002);
        clr = 1'b1;
        cyc(1);
        clr = 1'b0;
        cyc(3);
        check({alert, oe, stat, alert_oe_n}, 8'h0005);
        $display("test 2 done");
        host.xfer(1'b1, OCFR_CMD_CODE, 8'h008B, rd_v, ack_v);
        check(setting, 8'h008B);
        oc = 1'b1;
        wait_rst(80);
        check({7'h00, n >= 38 && n <= 46}, 8'h0001);
        wait_rst(80);
        check({6'h00, n >= 38 && n <= 46, stat}, 8'h0003);
        for (int k = 0; k < 4; k++)
        begin
            oc = 1'b1;
            cyc(6);
            {con, op, bias, oth} = stop_v[k];
            oc = 1'b0;
            wait_rst(60);
            check({7'h00, n < 0}, 8'h0001);
            {con, op, bias, oth, clr} = 5'h1D;
            cyc(1);
            clr = 1'b0;
        end
        $display("test 3 done");
        {grp, oc} = 2'h3;
        cyc(4);
        oc = 1'b0;
        wait_rst(60);
        check({6'h00, n < 0, oe}, 8'h0002);
        {grp, clr} = 2'h1;
        cyc(1);
        clr = 1'b0;
        host.xfer(1'b1, OCFR_CMD_CODE, 8'h000B, rd_v, ack_v);
        oc = 1'b1;
        cyc(4);
        check({oe, stat}, 8'h0001);
        oc = 1'b0;
        cyc(4);
        check({oe, stat}, 8'h0003);
        $display("test 4 done");
        wrap_up();
    end
endmodule : ocfr_core_bench
`default_nettype wire
